/* pkg/btq_consts.svh */
`ifndef BTQ_CONSTS_SVH
`define BTQ_CONSTS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define BTQ_DEPTH 4
`define BTQ_CNT_W 3
`define BTQ_TAG_W 8
`define BTQ_LEN_W 8
`define BTQ_TALLY_W 16
`define BTQ_QUOTA_W 16

// ----------------------------------------
// Descriptor fields
// ----------------------------------------
`define BTQ_DESC_W 16
`define BTQ_DESC_TAG_LSB 8
`define BTQ_DESC_LEN_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BTQ_TALLY_RST 16'h0000
`define BTQ_QUOTA_RST 16'h0000
`define BTQ_FILL_RST 3'h0
`define BTQ_CAPACITY 3'h4

`endif

/* pkg/btq_pkg.sv */
`include "btq_consts.svh"

package btq_pkg;

    typedef enum logic [1:0] {
        BTQ_BASIC,
        BTQ_AUTOMATIC,
        BTQ_USER
    } btq_policy_e;

    typedef enum logic {
        BTQ_CONTINUOUS,
        BTQ_COUNTED
    } btq_style_e;

    typedef enum logic {
        BTQ_IDLE,
        BTQ_SEND
    } btq_state_e;

    typedef struct packed {
        logic [`BTQ_TAG_W-1:0] tag;
        logic [`BTQ_LEN_W-1:0] len;
    } btq_desc_s;

endpackage

/* pkg/btq_queue_if.sv */
`timescale 1ns/1ps
`include "btq_consts.svh"

interface btq_queue_if #(
    parameter int WIDTH = `BTQ_DESC_W,
    parameter int CNT_W = `BTQ_CNT_W
);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [CNT_W-1:0] count;
    logic flush;

    modport ctrl (
        output in_valid, in_data, out_ready, flush,
        input in_ready, out_valid, out_data, count
    );

    modport store (
        input in_valid, in_data, out_ready, flush,
        output in_ready, out_valid, out_data, count
    );
endinterface

/* rtl/btq_fifo.sv */
`timescale 1ns/1ps

module btq_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int CNT_W = 3
) (
    input wire logic i_clk,
    input wire logic i_reset,
    btq_queue_if.store q
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic push;
    logic pop;

    assign q.in_ready = (count != FULL);
    assign q.out_valid = (count != '0);
    assign q.out_data = mem[rd_ptr];
    assign q.count = count;
    assign push = q.in_valid && q.in_ready && !q.flush;
    assign pop = q.out_valid && q.out_ready && !q.flush;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= q.in_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (q.flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count <= '0;
        end else if (q.flush) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule

/* rtl/btq_top.sv */
`timescale 1ns/1ps
`include "btq_consts.svh"

module btq_top (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire btq_pkg::btq_policy_e i_dispatch_policy,
    input wire btq_pkg::btq_style_e i_manual_send_style,
    input wire logic [`BTQ_QUOTA_W-1:0] i_burst_quota,
    input wire logic i_begin_sending_cmd,
    input wire logic i_halt_sending_cmd,
    input wire logic i_stream_close,
    input wire logic i_blk_valid,
    input wire logic [`BTQ_TAG_W-1:0] i_blk_tag,
    input wire logic [`BTQ_LEN_W-1:0] i_blk_len,
    output logic o_blk_ready,
    output logic o_pkt_valid,
    input wire logic i_pkt_ready,
    output logic [`BTQ_TAG_W-1:0] o_pkt_tag,
    output logic [`BTQ_LEN_W-1:0] o_pkt_index,
    output logic o_pkt_last,
    output logic [`BTQ_CNT_W-1:0] o_backlog_capacity,
    output logic [`BTQ_CNT_W-1:0] o_backlog_fill,
    output logic [`BTQ_TALLY_W-1:0] o_dropped_block_tally,
    output logic o_sending,
    output logic o_user_running
);

    // ----------------------------------------
    // Queue store
    // ----------------------------------------
    btq_queue_if #(
        .WIDTH(`BTQ_DESC_W),
        .CNT_W(`BTQ_CNT_W)
    ) q ();

    btq_fifo #(
        .WIDTH(`BTQ_DESC_W),
        .DEPTH(`BTQ_DEPTH),
        .CNT_W(`BTQ_CNT_W)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .q(q)
    );

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam logic [`BTQ_CNT_W-1:0] FULL_LEVEL = `BTQ_CAPACITY;

    btq_pkg::btq_desc_s stage_desc;
    btq_pkg::btq_desc_s head_desc;
    btq_pkg::btq_state_e state;
    btq_pkg::btq_state_e next_state;
    logic stage_valid;
    logic next_stage_valid;
    logic take_in;
    logic push;
    logic drop;
    logic gate;
    logic block_done;
    logic tx_take;
    logic pkt_advance;
    logic user_run;
    logic user_cmd_ok;
    logic [`BTQ_QUOTA_W-1:0] quota_left;
    logic [`BTQ_LEN_W-1:0] cur_last_idx;
    logic [`BTQ_LEN_W-1:0] head_last_idx;

    // ----------------------------------------
    // Staging of finished blocks
    // ----------------------------------------
    // Completed blocks only
    // A descriptor arrives once the block, chunk data included, is done.
    // One offered in a close cycle is lost: the producer sees it taken,
    // but staging is cleared with the rest of the stream state.
    assign take_in = i_blk_valid && o_blk_ready;

    assign push = stage_valid && q.in_ready;

    always_comb begin
        if (i_stream_close) begin
            next_stage_valid = 1'b0;
        end else if (take_in) begin
            next_stage_valid = 1'b1;
        end else if (push) begin
            next_stage_valid = 1'b0;
        end else begin
            next_stage_valid = stage_valid;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            stage_valid <= 1'b0;
        end else begin
            stage_valid <= next_stage_valid;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            stage_desc <= '0;
        end else if (take_in) begin
            stage_desc.tag <= i_blk_tag;
            stage_desc.len <= i_blk_len;
        end
    end

    // Ready is a flop so the producer sees a clean level
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_blk_ready <= 1'b0;
        end else begin
            o_blk_ready <= !next_stage_valid;
        end
    end

    // ----------------------------------------
    // Queue feed and overwrite
    // ----------------------------------------
    // Blocks wait in queue
    assign q.in_valid = stage_valid;
    assign q.in_data = stage_desc;

    assign q.flush = i_stream_close;

    // Drop oldest unsent
    // The block in flight sits in its own registers, so the queue
    // head is always the oldest block whose sending has not begun.
    assign drop = stage_valid && (q.count == FULL_LEVEL) && !tx_take
        && !i_stream_close;

    assign q.out_ready = drop || tx_take;

    assign head_desc = q.out_data;

    // ----------------------------------------
    // Dispatch gating
    // ----------------------------------------
    // User policy only
    assign user_cmd_ok = (i_dispatch_policy == btq_pkg::BTQ_USER);

    always_comb begin
        unique case (i_dispatch_policy)
            btq_pkg::BTQ_BASIC: gate = 1'b1;
            btq_pkg::BTQ_AUTOMATIC: gate = 1'b1;
            btq_pkg::BTQ_USER: gate = user_run;
            // Code 3 is no policy, so the gate stays shut for it
            default: gate = 1'b0;
        endcase
    end

    // Halt spares block
    // Halt only blocks new takes; the packet walk of the current
    // block carries on until its last packet is accepted.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            user_run <= 1'b0;
        end else if (i_stream_close) begin
            user_run <= 1'b0;
        // Halt is looked at first so it wins over a begin in one cycle
        end else if (user_cmd_ok && i_halt_sending_cmd) begin
            user_run <= 1'b0;
        end else if (user_cmd_ok && i_begin_sending_cmd) begin
            if (i_manual_send_style == btq_pkg::BTQ_COUNTED) begin
                user_run <= (i_burst_quota != '0);
            end else begin
                user_run <= 1'b1;
            end
        end else if (tx_take && user_cmd_ok
            && i_manual_send_style == btq_pkg::BTQ_COUNTED
            && quota_left <= `BTQ_QUOTA_W'(1)) begin
            user_run <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            quota_left <= `BTQ_QUOTA_RST;
        end else if (i_stream_close) begin
            quota_left <= `BTQ_QUOTA_RST;
        // A begin overridden by halt leaves the old quota in place
        end else if (user_cmd_ok && i_begin_sending_cmd
            && !i_halt_sending_cmd) begin
            quota_left <= i_burst_quota;
        end else if (tx_take && user_cmd_ok
            && i_manual_send_style == btq_pkg::BTQ_COUNTED
            && quota_left != '0) begin
            quota_left <= quota_left - 1'b1;
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    // Capture independent
    // Capture controls have no path into this logic at all.
    assign pkt_advance = o_pkt_valid && i_pkt_ready;

    assign block_done = (state == btq_pkg::BTQ_SEND) && pkt_advance
        && o_pkt_last;

    // Next oldest follows
    // The next block is taken in the cycle the last packet leaves.
    assign tx_take = ((state == btq_pkg::BTQ_IDLE) || block_done)
        && q.out_valid && gate && !i_stream_close;

    // Zero length counts as a single packet
    assign head_last_idx = (head_desc.len == '0) ? '0
        : head_desc.len - 1'b1;

    always_comb begin
        next_state = state;
        if (i_stream_close) begin
            next_state = btq_pkg::BTQ_IDLE;
        end else if (tx_take) begin
            next_state = btq_pkg::BTQ_SEND;
        end else if (block_done) begin
            next_state = btq_pkg::BTQ_IDLE;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= btq_pkg::BTQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pkt_valid <= 1'b0;
            o_pkt_tag <= '0;
            o_pkt_index <= '0;
            o_pkt_last <= 1'b0;
            cur_last_idx <= '0;
        end else if (i_stream_close) begin
            o_pkt_valid <= 1'b0;
            o_pkt_last <= 1'b0;
        end else if (tx_take) begin
            o_pkt_valid <= 1'b1;
            o_pkt_tag <= head_desc.tag;
            o_pkt_index <= '0;
            o_pkt_last <= (head_last_idx == '0);
            cur_last_idx <= head_last_idx;
        end else if (block_done) begin
            o_pkt_valid <= 1'b0;
            o_pkt_last <= 1'b0;
        end else if (pkt_advance) begin
            o_pkt_index <= o_pkt_index + 1'b1;
            o_pkt_last <= (o_pkt_index + 1'b1 == cur_last_idx);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sending <= 1'b0;
        end else begin
            o_sending <= (next_state == btq_pkg::BTQ_SEND);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_user_running <= 1'b0;
        end else begin
            o_user_running <= user_run;
        end
    end

    // ----------------------------------------
    // Status
    // ----------------------------------------
    // Capacity constant
    // Kept in a flop so that every output leaves a register
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_backlog_capacity <= `BTQ_CAPACITY;
        end else begin
            o_backlog_capacity <= `BTQ_CAPACITY;
        end
    end

    // Fill level
    // Lags the store by one cycle; good enough for software polling.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_backlog_fill <= `BTQ_FILL_RST;
        end else begin
            o_backlog_fill <= q.count;
        end
    end

    // Tally cleared
    // Saturates rather than wrapping so a long outage is not hidden.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_dropped_block_tally <= `BTQ_TALLY_RST;
        end else if (drop && (o_dropped_block_tally != '1)) begin
            o_dropped_block_tally <= o_dropped_block_tally + 1'b1;
        end
    end

endmodule

/* sim/btq_host_sink.sv */
`timescale 1ns/1ps
`include "btq_consts.svh"

// ----------------------------------------
// Host end of the stream channel
// ----------------------------------------
module btq_host_sink (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_stall,
    input wire logic i_flush,
    input wire logic i_pkt_valid,
    input wire logic [`BTQ_TAG_W-1:0] i_pkt_tag,
    input wire logic [`BTQ_LEN_W-1:0] i_pkt_index,
    input wire logic i_pkt_last,
    output logic o_pkt_ready,
    output int o_blocks,
    output int o_bad
);
    logic [`BTQ_TAG_W-1:0] rx_tags [0:15];
    logic [`BTQ_LEN_W-1:0] next_index;

    // Ready lags the stall request by a cycle, like a slow host
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pkt_ready <= 1'b0;
            o_blocks <= 0;
            o_bad <= 0;
            next_index <= 8'h00;
        end else begin
            o_pkt_ready <= !i_stall;
            if (i_flush) begin
                next_index <= 8'h00;
            end else if (i_pkt_valid && o_pkt_ready) begin
                if (i_pkt_index !== next_index) begin
                    o_bad <= o_bad + 1;
                end
                next_index <= i_pkt_last ? 8'h00 : i_pkt_index + 8'h01;
                if (i_pkt_last) begin
                    rx_tags[o_blocks[3:0]] <= i_pkt_tag;
                    o_blocks <= o_blocks + 1;
                end
            end
        end
    end
endmodule

/* sim/btq_checker_sva.sv */
`timescale 1ns/1ps
`include "btq_consts.svh"

module btq_checker (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire btq_pkg::btq_policy_e i_dispatch_policy,
    input wire logic i_begin_sending_cmd,
    input wire logic i_halt_sending_cmd,
    input wire logic i_stream_close,
    input wire logic i_pkt_ready,
    input wire logic o_pkt_valid,
    input wire logic [`BTQ_TAG_W-1:0] o_pkt_tag,
    input wire logic [`BTQ_LEN_W-1:0] o_pkt_index,
    input wire logic o_pkt_last,
    input wire logic [`BTQ_CNT_W-1:0] o_backlog_capacity,
    input wire logic [`BTQ_CNT_W-1:0] o_backlog_fill,
    input wire logic [`BTQ_TALLY_W-1:0] o_dropped_block_tally,
    input wire logic o_sending,
    input wire logic o_user_running
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_move;
        o_pkt_valid && i_pkt_ready && !i_stream_close;
    endsequence
    sequence s_wait;
        o_pkt_valid && !i_pkt_ready && !i_stream_close;
    endsequence
    // Three cycles used, though two suffice: the visible run flag lags the internal one by one cycle
    sequence s_shut;
        i_dispatch_policy == btq_pkg::BTQ_USER && !o_pkt_valid &&
            !i_begin_sending_cmd && !o_user_running;
    endsequence

    cap_const_a: assert property (o_backlog_capacity == `BTQ_CAPACITY)
        else $error("capacity value wrong");
    fill_bound_a: assert property (o_backlog_fill <= `BTQ_CAPACITY)
        else $error("fill above capacity");
    pkt_hold_a: assert property (s_wait |=> o_pkt_valid &&
        $stable(o_pkt_tag) && $stable(o_pkt_index))
        else $error("stalled packet changed");
    idx_step_a: assert property (s_move ##0 !o_pkt_last |=>
        o_pkt_valid && o_pkt_index == $past(o_pkt_index) + 8'h01)
        else $error("packet index did not step");
    // Fill one cycle on shows the queue level in the cycle of the take
    back_to_back_a: assert property (s_move ##0 (o_pkt_last &&
        (i_dispatch_policy == btq_pkg::BTQ_BASIC ||
        i_dispatch_policy == btq_pkg::BTQ_AUTOMATIC)) ##1
        o_backlog_fill != 3'h0 |->
        o_pkt_valid && o_pkt_index == 8'h00)
        else $error("gap between queued blocks");
    tally_step_a: assert property (!$stable(o_dropped_block_tally) |->
        o_dropped_block_tally == $past(o_dropped_block_tally) + 16'h0001)
        else $error("tally moved by other than one");
    gate_shut_a: assert property (s_shut [*3] |=> !o_pkt_valid)
        else $error("block sent without begin");
    halt_keep_a: assert property (o_pkt_valid && !o_pkt_last &&
        i_halt_sending_cmd && !i_stream_close |=> o_pkt_valid)
        else $error("halt cut a block short");
    close_flush_a: assert property (i_stream_close |->
        ##2 (o_backlog_fill == 3'h0 && !o_sending))
        else $error("close left work behind");
endmodule

bind btq_top btq_checker btq_checker_inst (.*);

/* sim/btq_top_tb_top.sv */
`timescale 1ns/1ps
`include "btq_consts.svh"

module btq_top_tb_top;
    typedef struct {
        btq_pkg::btq_policy_e pol;
        btq_pkg::btq_style_e sty;
        logic need_begin;
        logic [7:0] len;
    } btq_row_s;

    logic clk = 1'b0;
    logic reset = 1'b1;
    btq_pkg::btq_policy_e policy = btq_pkg::BTQ_BASIC;
    btq_pkg::btq_style_e style = btq_pkg::BTQ_CONTINUOUS;
    logic [15:0] quota = 16'h0002;
    logic begin_cmd = 1'b0;
    logic halt_cmd = 1'b0;
    logic close_cmd = 1'b0;
    logic blk_valid = 1'b0;
    logic [7:0] blk_tag = 8'h00;
    logic [7:0] blk_len = 8'h00;
    logic stall = 1'b0;
    logic blk_ready, pkt_valid, pkt_ready, pkt_last, sending, user_running;
    logic [7:0] pkt_tag, pkt_index;
    logic [2:0] cap, fill;
    logic [15:0] tally;
    int err_count = 0;
    int num_checks = 0;
    int base, k;
    // Basic, automatic, user continuous, user counted with zero length
    btq_row_s rows [4] = '{
        '{btq_pkg::BTQ_BASIC, btq_pkg::BTQ_CONTINUOUS, 1'b0, 8'h02},
        '{btq_pkg::BTQ_AUTOMATIC, btq_pkg::BTQ_CONTINUOUS, 1'b0, 8'h03},
        '{btq_pkg::BTQ_USER, btq_pkg::BTQ_CONTINUOUS, 1'b1, 8'h01},
        '{btq_pkg::BTQ_USER, btq_pkg::BTQ_COUNTED, 1'b1, 8'h00}};

    always #20 clk = ~clk;

    btq_top btq_top_inst (.i_clk(clk), .i_reset(reset),
        .i_dispatch_policy(policy), .i_manual_send_style(style),
        .i_burst_quota(quota), .i_begin_sending_cmd(begin_cmd),
        .i_halt_sending_cmd(halt_cmd), .i_stream_close(close_cmd),
        .i_blk_valid(blk_valid), .i_blk_tag(blk_tag), .i_blk_len(blk_len),
        .o_blk_ready(blk_ready), .o_pkt_valid(pkt_valid),
        .i_pkt_ready(pkt_ready), .o_pkt_tag(pkt_tag),
        .o_pkt_index(pkt_index), .o_pkt_last(pkt_last),
        .o_backlog_capacity(cap), .o_backlog_fill(fill),
        .o_dropped_block_tally(tally), .o_sending(sending),
        .o_user_running(user_running));

    btq_host_sink btq_host_sink_inst (.i_clk(clk), .i_reset(reset),
        .i_stall(stall), .i_flush(close_cmd), .i_pkt_valid(pkt_valid),
        .i_pkt_tag(pkt_tag), .i_pkt_index(pkt_index), .i_pkt_last(pkt_last),
        .o_pkt_ready(pkt_ready), .o_blocks(), .o_bad());

    task check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask

    // Holds the descriptor until the edge that samples ready high
    task push(input logic [7:0] tag, input logic [7:0] len);
        int n;
        blk_tag <= tag;
        blk_len <= len;
        blk_valid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (blk_ready === 1'b1) break;
        end
        if (n == 100) begin
            err_count++;
            $display("MISMATCH t=%0t block not taken", $time);
        end
        blk_valid <= 1'b0;
        @(posedge clk);
    endtask

    task pulse(input int which);
        if (which == 0) begin_cmd <= 1'b1;
        else if (which == 1) halt_cmd <= 1'b1;
        else close_cmd <= 1'b1;
        @(posedge clk);
        begin_cmd <= 1'b0;
        halt_cmd <= 1'b0;
        close_cmd <= 1'b0;
        @(posedge clk);
    endtask

    task wait_rx(input int n);
        int w;
        for (w = 0; w < 400; w++) begin
            if (btq_host_sink_inst.o_blocks >= n) break;
            @(posedge clk);
        end
        if (btq_host_sink_inst.o_blocks < n) begin
            err_count++;
            $display("MISMATCH t=%0t blocks not received", $time);
        end
    endtask

    function automatic logic [15:0] got(input int n);
        return 16'(btq_host_sink_inst.o_blocks - n);
    endfunction

    function automatic logic [15:0] tag_at(input int n);
        return {8'h00, btq_host_sink_inst.rx_tags[n % 16]};
    endfunction

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test;
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check(cap, `BTQ_CAPACITY, "capacity");
        check(fill, `BTQ_FILL_RST, "fill");
        check(tally, `BTQ_TALLY_RST, "tally");
        check({pkt_valid, sending, user_running}, 3'h0, "idle");
        $display("test reset done");
        foreach (rows[r]) begin
            base = btq_host_sink_inst.o_blocks;
            policy <= rows[r].pol;
            style <= rows[r].sty;
            @(posedge clk);
            if (rows[r].need_begin) pulse(0);
            push(8'(2 * r + 1), rows[r].len);
            push(8'(2 * r + 2), rows[r].len);
            wait_rx(base + 2);
            repeat (6) @(posedge clk);
            check(got(base), 16'h0002, "blocks");
            check(tag_at(base), 16'(2 * r + 1), "first");
            check(tag_at(base + 1), 16'(2 * r + 2), "second");
            check(fill, 3'h0, "drained");
            $display("test row %0d done", r);
        end
        base = btq_host_sink_inst.o_blocks;
        policy <= btq_pkg::BTQ_BASIC;
        stall <= 1'b1;
        push(8'h10, 8'h01);
        repeat (3) @(posedge clk);
        for (k = 0; k < 6; k++) push(8'(8'h11 + k), 8'h01);
        repeat (3) @(posedge clk);
        check(fill, 3'h4, "full");
        check(tally, 16'h0002, "dropped");
        check(pkt_tag, 8'h10, "in flight");
        check(sending, 1'b1, "busy");
        stall <= 1'b0;
        wait_rx(base + 5);
        for (k = 0; k < 5; k++)
            check(tag_at(base + k),
                k == 0 ? 16'h0010 : 16'(8'h12 + k), "fifo");
        $display("test overflow done");
        pulse(0);
        repeat (2) @(posedge clk);
        check(user_running, 1'b0, "ignored");
        base = btq_host_sink_inst.o_blocks;
        policy <= btq_pkg::BTQ_USER;
        style <= btq_pkg::BTQ_COUNTED;
        for (k = 0; k < 3; k++) push(8'(8'h20 + k), 8'h01);
        repeat (5) @(posedge clk);
        check(got(base), 16'h0000, "held");
        check(fill, 3'h3, "queued");
        pulse(0);
        wait_rx(base + 2);
        repeat (10) @(posedge clk);
        check(got(base), 16'h0002, "quota");
        check(fill, 3'h1, "left");
        check(user_running, 1'b0, "stopped");
        $display("test counted done");
        pulse(2);
        repeat (2) @(posedge clk);
        check(fill, 3'h0, "flushed");
        check(tally, 16'h0002, "kept");
        base = btq_host_sink_inst.o_blocks;
        style <= btq_pkg::BTQ_CONTINUOUS;
        stall <= 1'b1;
        push(8'h30, 8'h03);
        push(8'h31, 8'h01);
        pulse(0);
        repeat (2) @(posedge clk);
        pulse(1);
        stall <= 1'b0;
        repeat (20) @(posedge clk);
        check(got(base), 16'h0001, "one block");
        check(tag_at(base), 16'h0030, "finished");
        check(sending, 1'b0, "halted");
        check(fill, 3'h1, "gated");
        check(16'(btq_host_sink_inst.o_bad), 16'h0000, "packets");
        $display("test halt done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check(tally, `BTQ_TALLY_RST, "tally again");
        check(fill, `BTQ_FILL_RST, "fill again");
        check(sending, 1'b0, "idle again");
        $display("test reset again done");
        end_of_test;
    end
endmodule
